// ### pkg/npcd_pkg.sv
/*
 * npcd_pkg: register map, field positions, reset values and filter constants
 * for the channel phase-offset and fifth-order comb decimator block.
 * Assumes a single 125 MHz clock domain and a plain strobe register port.
 */
package npcd_pkg;
    // register port geometry
    localparam int unsigned REG_ADDR_W = 4;
    localparam int unsigned REG_DATA_W = 16;

    // register indices on the plain port
    localparam logic [3:0] ADDR_PHASE_OFFSET = 4'h0;
    localparam logic [3:0] ADDR_DECIMATION   = 4'h1;
    localparam logic [3:0] ADDR_SCALE        = 4'h2;
    localparam logic [3:0] ADDR_CONTROL      = 4'h3;
    localparam logic [3:0] ADDR_STATUS       = 4'h4;

    // field widths and positions
    localparam int unsigned PHASE_OFS_W    = 16;
    localparam int unsigned RATIO_FIELD_W  = 5;
    localparam int unsigned SCALE_FIELD_W  = 5;
    localparam int unsigned CTRL_BYPASS    = 0;
    localparam int unsigned STAT_OVERFLOW  = 0;
    localparam int unsigned STAT_BYPASSED  = 1;

    // reset values
    localparam logic [15:0] RST_PHASE_OFFSET = 16'h0000;
    localparam logic [4:0]  RST_RATIO_FIELD  = 5'h01;
    localparam logic [4:0]  RST_SCALE        = 5'h00;
    localparam logic        RST_BYPASS       = 1'b0;

    // filter structure
    localparam int unsigned COMB_STAGES    = 5;
    localparam logic [4:0]  RATIO_FIELD_MIN = 5'h01;
    localparam logic [4:0]  SCALE_MAX       = 5'h14;
    localparam logic [4:0]  SHIFT_BASE      = 5'h05;
    localparam int unsigned GROWTH_BITS    = COMB_STAGES * RATIO_FIELD_W;

    // clock and rate figures
    localparam real CLK_MHZ            = 125.0;
    localparam real MAX_INPUT_RATE_MHZ = 150.0;
endpackage

// ### src/npcd_integrators.sv
/*
 * npcd_integrators: chain of running-sum stages at the input sample rate.
 * Assumes the caller sign-extends the input to ACC_W; sums wrap on purpose.
 */
`timescale 1ns/10ps
module npcd_integrators #(
    parameter int unsigned ACC_W  = 41,
    parameter int unsigned STAGES = 5
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             ce_i,
    input  wire logic             en_i,
    input  wire logic [ACC_W-1:0] din_i,
    output logic      [ACC_W-1:0] dout_o
);
    logic [ACC_W-1:0] acc [STAGES];

    // each stage adds its predecessor; wraparound keeps the final difference exact
    for (genvar i = 0; i < STAGES; i++) begin : g_stage
        logic [ACC_W-1:0] src;
        if (i == 0) begin : g_first
            assign src = din_i;
        end else begin : g_rest
            assign src = acc[i-1];
        end
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                acc[i] <= '0;
            end else if (ce_i && en_i) begin
                acc[i] <= acc[i] + src;
            end
        end
    end

    assign dout_o = acc[STAGES-1];
endmodule // npcd_integrators

// ### src/npcd_combs.sv
/*
 * npcd_combs: chain of difference stages at the decimated rate.
 * Assumes en_i pulses once per output sample; one stored sample here spans
 * a full decimation period at the input rate.
 */
`timescale 1ns/10ps
module npcd_combs #(
    parameter int unsigned ACC_W  = 41,
    parameter int unsigned STAGES = 5
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             ce_i,
    input  wire logic             en_i,
    input  wire logic [ACC_W-1:0] din_i,
    output logic      [ACC_W-1:0] dout_o
);
    logic [ACC_W-1:0] dly [STAGES];
    logic [ACC_W-1:0] dif [STAGES];

    // pipelined differences; data moves one stage per decimated strobe
    for (genvar i = 0; i < STAGES; i++) begin : g_stage
        logic [ACC_W-1:0] src;
        if (i == 0) begin : g_first
            assign src = din_i;
        end else begin : g_rest
            assign src = dif[i-1];
        end
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                dly[i] <= '0;
                dif[i] <= '0;
            end else if (ce_i && en_i) begin
                dif[i] <= src - dly[i];
                dly[i] <= src;
            end
        end
    end

    assign dout_o = dif[STAGES-1];
endmodule // npcd_combs

// ### src/npcd_channel.sv
/*
 * npcd_channel: one receive channel's oscillator phase offset and its
 * fifth-order comb decimator with power-of-two scaling and bypass.
 * Assumes mixer samples arrive synchronous to clk_i with a valid strobe,
 * at most one per clock, and that the fixed filter chain follows.
 */
`timescale 1ns/10ps
module npcd_channel
    import npcd_pkg::*;
#(
    parameter int unsigned DATA_W  = 16,
    parameter int unsigned OUT_W   = 22,
    parameter int unsigned PHASE_W = 32
) (
    input  wire logic                            clk_i,
    input  wire logic                            rst_b_i,
    input  wire logic                            ce_i,
    input  wire logic [npcd_pkg::REG_ADDR_W-1:0] addr_i,
    input  wire logic [npcd_pkg::REG_DATA_W-1:0] wdata_i,
    input  wire logic                            wr_i,
    input  wire logic                            rd_i,
    output logic      [npcd_pkg::REG_DATA_W-1:0] rdata_o,
    input  wire logic [PHASE_W-1:0]              phase_acc_i,
    output logic      [PHASE_W-1:0]              phase_o,
    input  wire logic [DATA_W-1:0]               sample_i,
    input  wire logic                            sample_valid_i,
    output logic      [OUT_W-1:0]                comb_data_o,
    output logic                                 comb_valid_o
);
    import npcd_pkg::*;

    localparam int unsigned ACC_W = DATA_W + GROWTH_BITS;

    // software-visible state
    logic [PHASE_OFS_W-1:0]   phase_offset;
    logic [RATIO_FIELD_W-1:0] ratio_field;
    logic [SCALE_FIELD_W-1:0] scale_field;
    logic                     bypass;
    logic                     overflow;

    // decimation and datapath state
    logic [RATIO_FIELD_W-1:0] dec_cnt;
    logic                     comb_en;
    logic                     comb_done;
    logic [ACC_W-1:0]         integ_in;
    logic [ACC_W-1:0]         integ_out;
    logic [ACC_W-1:0]         comb_out;

    // derived combinational values
    logic [RATIO_FIELD_W-1:0] eff_field;
    logic [SCALE_FIELD_W-1:0] eff_scale;
    logic [SCALE_FIELD_W-1:0] shift_amt;
    logic [ACC_W-1:0]         shifted;
    logic [OUT_W-1:0]         next_scaled;
    logic                     next_ovf;
    logic                     wr_phase;
    logic                     wr_ratio;
    logic                     wr_scale;
    logic                     wr_ctrl;
    logic                     wr_stat;
    logic                     integ_en;
    logic                     last_of_period;

    // address decode for writes; ce low freezes the port along with the rest
    assign wr_phase = wr_i && (addr_i == ADDR_PHASE_OFFSET);
    assign wr_ratio = wr_i && (addr_i == ADDR_DECIMATION);
    assign wr_scale = wr_i && (addr_i == ADDR_SCALE);
    assign wr_ctrl  = wr_i && (addr_i == ADDR_CONTROL);
    assign wr_stat  = wr_i && (addr_i == ADDR_STATUS);

    // phase offset register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_offset <= RST_PHASE_OFFSET;
        end else if (ce_i && wr_phase) begin
            phase_offset <= wdata_i[PHASE_OFS_W-1:0];
        end
    end

    // decimation setting holds ratio minus one
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ratio_field <= RST_RATIO_FIELD;
        end else if (ce_i && wr_ratio) begin
            ratio_field <= wdata_i[RATIO_FIELD_W-1:0];
        end
    end

    // scale factor register, stored as written and clamped on use
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scale_field <= RST_SCALE;
        end else if (ce_i && wr_scale) begin
            scale_field <= wdata_i[SCALE_FIELD_W-1:0];
        end
    end

    // control register: bypass selects a ratio of one
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bypass <= RST_BYPASS;
        end else if (ce_i && wr_ctrl) begin
            bypass <= wdata_i[CTRL_BYPASS];
        end
    end

    // sticky saturation flag; a new overflow beats a write-one clear
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            overflow <= 1'b0;
        end else if (ce_i) begin
            if (comb_done && !bypass && next_ovf) begin
                overflow <= 1'b1;
            end else if (wr_stat && wdata_i[STAT_OVERFLOW]) begin
                overflow <= 1'b0;
            end
        end
    end

    // read data stands for exactly the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= '0;
            if (rd_i) begin
                case (addr_i)
                    ADDR_PHASE_OFFSET: rdata_o[PHASE_OFS_W-1:0]   <= phase_offset;
                    ADDR_DECIMATION:   rdata_o[RATIO_FIELD_W-1:0] <= ratio_field;
                    ADDR_SCALE:        rdata_o[SCALE_FIELD_W-1:0] <= scale_field;
                    ADDR_CONTROL:      rdata_o[CTRL_BYPASS]       <= bypass;
                    ADDR_STATUS: begin
                        rdata_o[STAT_OVERFLOW] <= overflow;
                        rdata_o[STAT_BYPASSED] <= bypass;
                    end
                    default:           rdata_o <= '0;
                endcase
            end
        end
    end

    // offset sits at the top of the accumulator so all ones is one lsb short of a turn
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_o <= '0;
        end else if (ce_i) begin
            phase_o <= phase_acc_i + {phase_offset, {(PHASE_W-PHASE_OFS_W){1'b0}}};
        end
    end

    // a field below one would mean ratio one, which only bypass may give
    assign eff_field = (ratio_field < RATIO_FIELD_MIN) ? RATIO_FIELD_MIN : ratio_field;
    assign eff_scale = (scale_field > SCALE_MAX) ? SCALE_MAX : scale_field;
    assign shift_amt = eff_scale + SHIFT_BASE;

    // integrators run on every valid input sample while the stage is in use
    assign integ_en = sample_valid_i && !bypass;
    assign integ_in = {{(ACC_W-DATA_W){sample_i[DATA_W-1]}}, sample_i};
    assign last_of_period = (dec_cnt == eff_field);

    npcd_integrators #(
        .ACC_W  (ACC_W),
        .STAGES (COMB_STAGES)
    ) u_integrators (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .en_i    (integ_en),
        .din_i   (integ_in),
        .dout_o  (integ_out)
    );

    // decimation counter: one comb strobe per field-plus-one input samples, two for a zero field;
    // rewriting the ratio restarts the period so the first output is aligned
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dec_cnt <= '0;
            comb_en <= 1'b0;
        end else if (ce_i) begin
            comb_en <= 1'b0;
            if (wr_ratio || bypass) begin
                dec_cnt <= '0;
            end else if (integ_en) begin
                if (last_of_period) begin
                    dec_cnt <= '0;
                    comb_en <= 1'b1;
                end else begin
                    dec_cnt <= dec_cnt + 5'h01;
                end
            end
        end
    end

    npcd_combs #(
        .ACC_W  (ACC_W),
        .STAGES (COMB_STAGES)
    ) u_combs (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .en_i    (comb_en),
        .din_i   (integ_out),
        .dout_o  (comb_out)
    );

    // comb result is ready one cycle after its strobe
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            comb_done <= 1'b0;
        end else if (ce_i) begin
            comb_done <= comb_en;
        end
    end

    // arithmetic shift by scale plus five, then saturate into the output width;
    // saturation only shows up if software picked too small a scale
    always_comb begin
        shifted     = $signed(comb_out) >>> shift_amt;
        next_ovf    = 1'b0;
        next_scaled = shifted[OUT_W-1:0];
        if (shifted[ACC_W-1:OUT_W-1] != {(ACC_W-OUT_W+1){shifted[ACC_W-1]}}) begin
            next_ovf    = 1'b1;
            next_scaled = {shifted[ACC_W-1], {(OUT_W-1){~shifted[ACC_W-1]}}};
        end
    end

    // output register feeding the fixed filter cascade; bypass passes input through
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            comb_data_o  <= '0;
            comb_valid_o <= 1'b0;
        end else if (ce_i) begin
            comb_valid_o <= 1'b0;
            if (bypass) begin
                if (sample_valid_i) begin
                    // no scaling in bypass, the sample is only sign-extended
                    comb_data_o  <= {{(OUT_W-DATA_W){sample_i[DATA_W-1]}}, sample_i};
                    comb_valid_o <= 1'b1;
                end
            end else if (comb_done) begin
                comb_data_o  <= next_scaled;
                comb_valid_o <= 1'b1;
            end
        end
    end

    // one sample per clock at 125 MHz is the ceiling here; a 150 MHz input rate
    // needs the same logic clocked at the input port rate
    localparam real RATE_HEADROOM = MAX_INPUT_RATE_MHZ / CLK_MHZ;
endmodule // npcd_channel

// ### test/npcd_mixer_model.sv
/* npcd_mixer_model: upstream oscillator and mixer stand-in that steps a phase
   accumulator and offers a held sample level, with optional idle gaps.
   Assumes the bench owns the step, the level and the run and gap switches. */
`timescale 1ns/10ps
module npcd_mixer_model (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        run_i,
    input  wire logic        gaps_i,
    input  wire logic [15:0] level_i,
    input  wire logic [31:0] step_i,
    output logic      [31:0] phase_acc_o = 32'h0000_0000,
    output logic      [15:0] sample_o = 16'h0000,
    output logic             valid_o = 1'b0
);
    logic v;
    // a frequency move is just a new step; the accumulator runs on unbroken
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_acc_o <= 32'h0000_0000;
            sample_o <= 16'h0000;
            valid_o <= 1'b0;
        end else begin
            v = run_i && !(gaps_i && $urandom_range(2) == 0);
            phase_acc_o <= phase_acc_o + step_i;
            valid_o <= v;
            // idle cycles toggle the word so stale data never looks valid
            sample_o <= v ? level_i : ~sample_o;
        end
    end
endmodule // npcd_mixer_model

// ### test/npcd_channel_monitor.sv
/* npcd_channel_monitor: port-level checks of phase, register and decimator paths.
   Assumes it is bound to npcd_channel and that samples stop during writes. */
`timescale 1ns/10ps
module npcd_channel_monitor
    import npcd_pkg::*;
#(
    parameter int unsigned DATA_W  = 16,
    parameter int unsigned OUT_W   = 22,
    parameter int unsigned PHASE_W = 32
) (
    input wire logic                            clk_i,
    input wire logic                            rst_b_i,
    input wire logic                            ce_i,
    input wire logic [npcd_pkg::REG_ADDR_W-1:0] addr_i,
    input wire logic [npcd_pkg::REG_DATA_W-1:0] wdata_i,
    input wire logic                            wr_i,
    input wire logic                            rd_i,
    input wire logic [npcd_pkg::REG_DATA_W-1:0] rdata_o,
    input wire logic [PHASE_W-1:0]              phase_acc_i,
    input wire logic [PHASE_W-1:0]              phase_o,
    input wire logic [DATA_W-1:0]               sample_i,
    input wire logic                            sample_valid_i,
    input wire logic [OUT_W-1:0]                comb_data_o,
    input wire logic                            comb_valid_o
);
    logic [15:0] sh_ofs;
    logic [4:0]  sh_rat;
    logic        sh_byp;
    logic        clean;
    logic [5:0]  cnt;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // mirror of software writes, so the mode is known without looking inside
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sh_ofs <= RST_PHASE_OFFSET;
            sh_rat <= RST_RATIO_FIELD;
            sh_byp <= RST_BYPASS;
        end else if (ce_i && wr_i) begin
            if (addr_i == ADDR_PHASE_OFFSET) sh_ofs <= wdata_i;
            if (addr_i == ADDR_DECIMATION) sh_rat <= wdata_i[4:0];
            if (addr_i == ADDR_CONTROL) sh_byp <= wdata_i[0];
        end
    end
    // samples seen two cycles late line up with the output strobe; the edge that
    // sees the strobe starts the new count with its own sample instead of dropping it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 6'h00;
            clean <= 1'b0;
        end else begin
            cnt <= comb_valid_o ? 6'($past(sample_valid_i, 2))
                                : cnt + 6'($past(sample_valid_i, 2));
            clean <= !wr_i && (comb_valid_o || clean);
        end
    end
    chk_phase_offset: assert property (
        $past(ce_i) && $past(rst_b_i) |-> phase_o == $past(phase_acc_i) + {$past(sh_ofs), 16'h0000})
        else $error("phase output differs from accumulator plus offset");
    chk_offset_read: assert property (
        rd_i && addr_i == ADDR_PHASE_OFFSET |=> rdata_o == $past(sh_ofs))
        else $error("offset readback wrong");
    chk_ratio_read: assert property (
        rd_i && addr_i == ADDR_DECIMATION |=> rdata_o == {11'h000, $past(sh_rat)})
        else $error("ratio readback wrong");
    chk_idle_zero: assert property (ce_i && !rd_i |=> rdata_o == 16'h0000)
        else $error("read data not zero outside a read");
    chk_unmapped_zero: assert property (rd_i && addr_i > ADDR_STATUS |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    chk_bypass_pass: assert property (
        sh_byp && sample_valid_i |=> comb_valid_o && comb_data_o ==
        {{(OUT_W-DATA_W){$past(sample_i[DATA_W-1])}}, $past(sample_i)})
        else $error("bypass output differs from input");
    chk_ratio_count: assert property (
        comb_valid_o && clean && !sh_byp |->
        cnt == ((sh_rat == 5'h00) ? 6'h02 : 6'(sh_rat) + 6'h01))
        else $error("input samples per output differ from ratio");
    chk_single_pulse: assert property (comb_valid_o && !sh_byp |=> !comb_valid_o)
        else $error("decimated strobe longer than one cycle");
endmodule // npcd_channel_monitor

bind npcd_channel npcd_channel_monitor #(.DATA_W(DATA_W), .OUT_W(OUT_W), .PHASE_W(PHASE_W))
    i_npcd_channel_monitor (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .phase_acc_i(phase_acc_i),
    .phase_o(phase_o), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
    .comb_data_o(comb_data_o), .comb_valid_o(comb_valid_o));

// ### test/tb_top.sv
/* tb_top: self-checking bench for npcd_channel fed by the mixer model.
   Assumes the monitor is bound from its own file. */
`timescale 1ns/10ps
module tb_top;
    import npcd_pkg::*;
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
    logic        clk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic        sample_valid_i, comb_valid_o, run = 1'b0, gaps = 1'b0, v = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000, rdata_o, sample_i, level = 16'h0000, xs;
    logic [15:0] ofs[4] = '{16'h0000, 16'hffff, 16'h8000, 16'h1234};
    logic [31:0] phase_acc_i, phase_o, p, step = 32'h0000_0000;
    logic [21:0] comb_data_o;
    int          rt[5] = '{2, 4, 8, 16, 32};
    int          mismatches = 0, n_compared = 0, r;

    npcd_channel i_npcd_channel (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .phase_acc_i(phase_acc_i), .phase_o(phase_o), .sample_i(sample_i),
        .sample_valid_i(sample_valid_i), .comb_data_o(comb_data_o), .comb_valid_o(comb_valid_o));
    npcd_mixer_model i_npcd_mixer_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .run_i(run),
        .gaps_i(gaps), .level_i(level), .step_i(step), .phase_acc_o(phase_acc_i),
        .sample_o(sample_i), .valid_o(sample_valid_i));

    initial forever #4 clk_i = ~clk_i;

    task automatic give_verdict();
        if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_i);
        addr_i <= a; rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 `CHECK("rdata", e, rdata_o)
    endtask
    // full-precision gain, then the power-of-two shift and output saturation
    function automatic logic [21:0] exp_out(int r, int s, logic signed [15:0] x);
        longint q;
        // scale settings above twenty act as twenty
        q = (longint'(x) * r * r * r * r * r) >>> ((s > 20 ? 20 : s) + 5);
        if (q > 2097151) q = 2097151;
        if (q < -2097152) q = -2097152;
        return q[21:0];
    endfunction
    // smallest shift that keeps the gain times input level within full scale
    function automatic int rec_scale(int r, logic signed [15:0] x);
        longint m;
        int s;
        m = (x < 0 ? -longint'(x) : longint'(x)) * r * r * r * r * r;
        s = 0;
        while (s < 20 && m > (longint'(1) << (s + 20))) s++;
        return s;
    endfunction
    // pipeline drains before reprogramming; twelve outputs flush old history
    task automatic run_case(int r, int s, logic [15:0] x, logic g);
        int n;
        int re;
        re = (r < 2) ? 2 : r; // a zero field decimates by two, never by one
        @(posedge clk_i);
        run <= 1'b0;
        repeat (6) @(posedge clk_i);
        wr_reg(ADDR_DECIMATION, 16'(r - 1));
        wr_reg(ADDR_SCALE, 16'(s));
        level <= x; gaps <= g; run <= 1'b1;
        n = 0;
        for (int t = 0; t < 4000 && n < 12; t++) begin
            @(posedge clk_i);
            #1 if (comb_valid_o === 1'b1) n++;
        end
        `CHECK("outputs", 12, n)
        `CHECK("comb_data", exp_out(re, s, x), comb_data_o)
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end

    initial begin
        void'($urandom(14));
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd_chk(ADDR_PHASE_OFFSET, 16'h0000);
        rd_chk(ADDR_DECIMATION, 16'h0001);
        rd_chk(ADDR_SCALE, 16'h0000);
        rd_chk(4'hf, 16'h0000);
        // offset at both ends of the turn while the accumulator steps
        @(posedge clk_i);
        step <= $urandom; run <= 1'b1;
        foreach (ofs[i]) begin
            wr_reg(ADDR_PHASE_OFFSET, ofs[i]);
            // settled accumulator value, the one the next edge adds the offset to
            #1 p = phase_acc_i;
            @(posedge clk_i);
            #1 `CHECK("phase", p + {ofs[i], 16'h0000}, phase_o)
        end
        // power-of-two ratios with matching shift return the input level
        foreach (rt[i]) run_case(rt[i], 5 * i, 16'($urandom_range(4095)) - 16'h0800, i[0]);
        run_case(3, 3, 16'h0100, 1'b0);
        repeat (4) begin
            r = $urandom_range(32, 2);
            xs = 16'($urandom);
            run_case(r, rec_scale(r, xs), xs, 1'b1);
        end
        // zero ratio field and an over-range scale: both clamp, neither gives ratio one
        run_case(1, 31, 16'h8000, 1'b0);
        run_case(32, 0, 16'h4000, 1'b1);
        @(posedge clk_i);
        run <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd_chk(ADDR_STATUS, 16'h0001);
        wr_reg(ADDR_STATUS, 16'h0001);
        wr_reg(ADDR_CONTROL, 16'h0001);
        rd_chk(ADDR_STATUS, 16'h0002);
        // bypass: every input sample comes straight out one cycle later
        @(posedge clk_i);
        gaps <= 1'b1; run <= 1'b1;
        repeat (60) begin
            @(posedge clk_i);
            level <= 16'($urandom);
            #1 `CHECK("bypass_valid", v, comb_valid_o)
            if (v) `CHECK("bypass_data", {{6{xs[15]}}, xs}, comb_data_o)
            v = sample_valid_i;
            xs = sample_i;
        end
        give_verdict();
    end
endmodule // tb_top
